// [core/ccm_fmt_pkg.sv]
// constants, types and field layouts for the ccm frame security formatter
// assumes a single 50 MHz clock domain and octet-wide frame streams
package ccm_fmt_pkg;

    // register offsets on the plain register port
    localparam logic [3:0] REG_CTRL    = 4'h0;
    localparam logic [3:0] REG_ADDR_LO = 4'h1;
    localparam logic [3:0] REG_ADDR_HI = 4'h2;
    localparam logic [3:0] REG_STATUS  = 4'h3;
    localparam logic [3:0] REG_COUNTER = 4'h4;

    // control register fields
    localparam int CTRL_LEVEL_LSB = 0;
    localparam int CTRL_INVERSE   = 3;
    localparam int CTRL_SEC_EN    = 4;
    localparam int CTRL_ERR_CLR   = 5;
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // security control octet layout
    localparam int SC_LEVEL_LSB = 0;
    localparam int SC_KMODE_LSB = 3;

    // octet counts
    localparam int NONCE_OCTETS = 13;
    localparam int ADDR_OCTETS  = 8;
    localparam int FC_OCTETS    = 4;
    localparam logic [1:0] CCM_LEN_FIELD = 2'h2;
    localparam logic [3:0] FC_LAST_IDX   = 4'h3;

    // encryption-only level, the one active level whose forward a data is empty
    localparam logic [2:0] LEVEL_ENC_ONLY = 3'h4;

    typedef enum logic [2:0] {
        SECT_HDR,
        SECT_AUX,
        SECT_NONPAY,
        SECT_PAYLOAD,
        SECT_TAG
    } sect_e;

    typedef enum {
        AUX_CTRL,
        AUX_CNT,
        AUX_KEY,
        AUX_DONE
    } aux_e;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        sect_e      sect;
        logic       last;
    } frame_octet_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } octet_s;

    typedef struct packed {
        logic       active;
        logic       inverse;
        logic       encrypt;
        logic [4:0] tag_len;
        logic [1:0] len_field;
        logic       cipher_aes;
    } eng_cfg_s;

    // tag length in octets from level bits 1:0
    function automatic logic [4:0] tag_len_of(input logic [1:0] m);
        case (m)
            2'h0: tag_len_of = 5'h00;
            2'h1: tag_len_of = 5'h04;
            2'h2: tag_len_of = 5'h08;
            default: tag_len_of = 5'h10;
        endcase
    endfunction

    // key identifier length in octets from key identifier mode
    function automatic logic [3:0] key_len_of(input logic [1:0] k);
        case (k)
            2'h0: key_len_of = 4'h0;
            2'h1: key_len_of = 4'h1;
            2'h2: key_len_of = 4'h5;
            default: key_len_of = 4'h9;
        endcase
    endfunction

endpackage

// [core/ccm_frame_security_formatter.sv]
// frame security formatter: routes frame octets into ccm a and m/c streams
// assumes an external aes ccm engine and frame assembly logic, one clock
//
// The address map and the strobed register port were chosen for this implementation.
module ccm_frame_security_formatter
    import ccm_fmt_pkg::*;
(
    input  wire logic         clock,      // 50 MHz clock
    input  wire logic         rstn,       // async reset, active low
    input  wire logic [3:0]   reg_addr,   // register offset
    input  wire logic [31:0]  reg_wdata,  // register write data
    input  wire logic         reg_wr,     // write strobe
    input  wire logic         reg_rd,     // read strobe
    output logic [31:0]       reg_rdata,  // read data, cycle after strobe
    input  wire frame_octet_s frm_in,     // frame octets with section tag
    input  wire octet_s       res_in,     // engine result octets
    output logic              res_ready,  // result taken this cycle
    output octet_s            eng_a,      // a data octets to engine
    output octet_s            eng_m,      // m or c data octets to engine
    output octet_s            frm_out,    // rebuilt frame octets
    output logic              frm_end,    // pulse after last frame octet
    output eng_cfg_s          eng_cfg,    // engine configuration
    output logic [12:0][7:0]  nonce       // index 0 is the first octet
);

    // register file state
    logic [5:0]  ctrl_q, ctrl_d;
    logic [63:0] addr_q, addr_d;
    logic [31:0] rdata_q, rdata_d;

    // aux header parser state
    aux_e        aux_q, aux_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [2:0]  slvl_q, slvl_d;
    logic [1:0]  kmode_q, kmode_d;
    logic [31:0] fc_q, fc_d;
    logic        aux_err_q, aux_err_d;
    logic        mis_err_q, mis_err_d;

    // stream output registers
    octet_s      a_q, a_d, m_q, m_d, o_q, o_d;
    logic        end_q, end_d;

    logic [2:0]  level;
    logic        active, inverse, encrypt, clr, is_hdr;
    logic        set_aux, set_mis;

    // level from control, forced to zero when security is off
    assign level   = ctrl_q[CTRL_SEC_EN] ? ctrl_q[CTRL_LEVEL_LSB +: 3] : 3'h0;
    assign active  = (level != 3'h0);
    assign encrypt = level[2];
    assign inverse = ctrl_q[CTRL_INVERSE];
    assign clr     = reg_wr && (reg_addr == REG_CTRL) &&
                     reg_wdata[CTRL_ERR_CLR];
    assign is_hdr  = (frm_in.sect == SECT_HDR) || (frm_in.sect == SECT_AUX) ||
                     (frm_in.sect == SECT_NONPAY);

    // register writes and read mux; unmapped offsets read as zero
    always_comb begin
        ctrl_d  = ctrl_q;
        addr_d  = addr_q;
        rdata_d = 32'h0000_0000;
        if (reg_wr && reg_addr == REG_CTRL) begin
            ctrl_d = {1'b0, reg_wdata[4:0]};
        end
        if (reg_wr && reg_addr == REG_ADDR_LO) begin
            addr_d[31:0] = reg_wdata;
        end
        if (reg_wr && reg_addr == REG_ADDR_HI) begin
            addr_d[63:32] = reg_wdata;
        end
        if (reg_rd) begin
            case (reg_addr)
                REG_CTRL:    rdata_d = {26'h0, ctrl_q};
                REG_ADDR_LO: rdata_d = addr_q[31:0];
                REG_ADDR_HI: rdata_d = addr_q[63:32];
                REG_STATUS:  rdata_d = {24'h0, mis_err_q, aux_err_q,
                                        (aux_q == AUX_DONE), kmode_q, slvl_q};
                REG_COUNTER: rdata_d = fc_q;
                default:     rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_q  <= CTRL_RESET;
            addr_q  <= 64'h0;
            rdata_q <= 32'h0;
        end else begin
            ctrl_q  <= ctrl_d;
            addr_q  <= addr_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // aux header parser; counter octets arrive least significant first
    always_comb begin
        aux_d   = aux_q;
        cnt_d   = cnt_q;
        slvl_d  = slvl_q;
        kmode_d = kmode_q;
        fc_d    = fc_q;
        set_aux = 1'b0;
        set_mis = 1'b0;
        if (frm_in.valid && frm_in.sect == SECT_AUX) begin
            if (!ctrl_q[CTRL_SEC_EN]) begin
                set_aux = 1'b1;
            end
            case (aux_q)
                AUX_CTRL: begin
                    slvl_d  = frm_in.data[SC_LEVEL_LSB +: 3];
                    kmode_d = frm_in.data[SC_KMODE_LSB +: 2];
                    set_mis = (frm_in.data[SC_LEVEL_LSB +: 3] != level);
                    cnt_d   = 4'h0;
                    aux_d   = AUX_CNT;
                end
                AUX_CNT: begin
                    fc_d[cnt_q[1:0]*8 +: 8] = frm_in.data;
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == FC_LAST_IDX) begin
                        cnt_d = 4'h0;
                        aux_d = (kmode_q == 2'h0) ? AUX_DONE : AUX_KEY;
                    end
                end
                AUX_KEY: begin
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q + 4'h1 == key_len_of(kmode_q)) begin
                        aux_d = AUX_DONE;
                    end
                end
                AUX_DONE: set_aux = 1'b1;
                default:  aux_d = AUX_CTRL;
            endcase
        end
        // a body octet before a complete aux header breaks the layout
        if (frm_in.valid && ctrl_q[CTRL_SEC_EN] && !is_hdr &&
            aux_q != AUX_DONE) begin
            set_aux = 1'b1;
        end
        if (frm_in.valid && frm_in.last) begin
            aux_d = AUX_CTRL;
        end
        // a new error wins over a clear in the same cycle
        aux_err_d = set_aux | (aux_err_q & ~clr);
        mis_err_d = set_mis | (mis_err_q & ~clr);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            aux_q     <= AUX_CTRL;
            cnt_q     <= 4'h0;
            slvl_q    <= 3'h0;
            kmode_q   <= 2'h0;
            fc_q      <= 32'h0;
            aux_err_q <= 1'b0;
            mis_err_q <= 1'b0;
        end else begin
            aux_q     <= aux_d;
            cnt_q     <= cnt_d;
            slvl_q    <= slvl_d;
            kmode_q   <= kmode_d;
            fc_q      <= fc_d;
            aux_err_q <= aux_err_d;
            mis_err_q <= mis_err_d;
        end
    end

    // nonce assembly, integers least significant octet first
    genvar gi;
    generate
        for (gi = 0; gi < NONCE_OCTETS; gi++) begin : g_nonce
            if (gi < ADDR_OCTETS) begin : g_addr
                assign nonce[gi] = addr_q[gi*8 +: 8];
            end else if (gi < ADDR_OCTETS + FC_OCTETS) begin : g_fc
                assign nonce[gi] = fc_q[(gi-ADDR_OCTETS)*8 +: 8];
            end else begin : g_lvl
                assign nonce[gi] = {5'h00, slvl_q};
            end
        end
    endgenerate

    // engine configuration from the programmed level
    assign eng_cfg.active     = active;
    assign eng_cfg.inverse    = inverse;
    assign eng_cfg.encrypt    = encrypt;
    assign eng_cfg.tag_len    = tag_len_of(level[1:0]);
    assign eng_cfg.len_field  = CCM_LEN_FIELD;
    assign eng_cfg.cipher_aes = 1'b1;

    // results only enter the frame when no input octet competes
    assign res_ready = !frm_in.valid;

    // octet routing into a, m/c and rebuilt frame streams
    always_comb begin
        a_d   = '{valid: 1'b0, data: frm_in.data};
        m_d   = '{valid: 1'b0, data: frm_in.data};
        o_d   = '{valid: 1'b0, data: frm_in.data};
        end_d = frm_in.valid && frm_in.last;
        if (frm_in.valid) begin
            if (is_hdr) begin
                o_d.valid = 1'b1;
                // forward level 4 authenticates nothing
                a_d.valid = active &&
                            (inverse || level != LEVEL_ENC_ONLY);
            end else if (frm_in.sect == SECT_PAYLOAD) begin
                a_d.valid = active && !encrypt;
                m_d.valid = active && encrypt;
                o_d.valid = !(active && encrypt);
            end else if (frm_in.sect == SECT_TAG) begin
                m_d.valid = active && inverse;
                o_d.valid = !active;
            end
        end else if (res_in.valid) begin
            o_d = res_in;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            a_q   <= '0;
            m_q   <= '0;
            o_q   <= '0;
            end_q <= 1'b0;
        end else begin
            a_q   <= a_d;
            m_q   <= m_d;
            o_q   <= o_d;
            end_q <= end_d;
        end
    end

    assign eng_a   = a_q;
    assign eng_m   = m_q;
    assign frm_out = o_q;
    assign frm_end = end_q;

    // checks on routing, configuration, nonce capture and the aux error flag
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    lvl0_quiet_a: assert property (
        frm_in.valid && !active |=> !eng_a.valid && !eng_m.valid)
        else $error("level zero fed the engine");
    lvl0_pass_a: assert property (
        frm_in.valid && !active && frm_in.sect == SECT_PAYLOAD |=>
        frm_out.valid && frm_out.data == $past(frm_in.data))
        else $error("level zero payload not passed");
    tag_len_a: assert property (
        eng_cfg.tag_len ==
        (level[1:0] == 2'h0 ? 5'h00 : (5'h02 << level[1:0])))
        else $error("tag length does not match level");
    len_field_a: assert property (
        eng_cfg.len_field == 2'h2 && eng_cfg.cipher_aes)
        else $error("length field or cipher wrong");
    enc_payload_a: assert property (
        frm_in.valid && active && encrypt && frm_in.sect == SECT_PAYLOAD |=>
        eng_m.valid && !frm_out.valid && !eng_a.valid)
        else $error("encrypted payload misrouted");
    fwd_enc_only_a: assert property (
        frm_in.valid && !inverse && level == LEVEL_ENC_ONLY && is_hdr |=>
        !eng_a.valid && frm_out.valid)
        else $error("level 4 forward fed a data");
    inv_tag_a: assert property (
        frm_in.valid && active && inverse && frm_in.sect == SECT_TAG |=>
        eng_m.valid && !frm_out.valid)
        else $error("received tag not sent as c data");
    nonce_level_a: assert property (
        frm_in.valid && frm_in.sect == SECT_AUX && aux_q == AUX_CTRL |=>
        nonce[12] == {5'h00, $past(frm_in.data[2:0])})
        else $error("nonce level octet not captured");
    sec_off_aux_a: assert property (
        frm_in.valid && frm_in.sect == SECT_AUX && !ctrl_q[CTRL_SEC_EN] |=>
        aux_err_q)
        else $error("aux header without security not flagged");
    res_sub_a: assert property (
        res_in.valid && !frm_in.valid |=>
        frm_out.valid && frm_out.data == $past(res_in.data))
        else $error("engine result not placed in frame");

    fwd_full_c: cover property (
        !inverse && level == 3'h7 && eng_a.valid ##1 eng_m.valid);
    inv_auth_c: cover property (
        inverse && level == 3'h3 && eng_a.valid ##1 eng_m.valid);
    lvl0_pass_c: cover property (!active && frm_out.valid ##1 frm_end);
    res_out_c: cover property (res_in.valid && res_ready ##1 frm_out.valid);

endmodule

// [bench/ccm_engine_model.sv]
// engine stand-in: collects m/c octets, later returns result octets
// assumes the formatter's octet_s carrier and its res_ready handshake
module ccm_engine_model
    import ccm_fmt_pkg::*;
(
    input  wire logic       clock,      // bench clock
    input  wire logic       rstn,       // async reset, active low
    input  wire octet_s     eng_m,      // m or c octets from formatter
    input  wire logic       res_ready,  // result taken when high
    input  wire logic       go,         // start returning results
    input  wire logic       slow,       // idle a cycle after each octet
    input  wire logic [4:0] n_body,     // transformed payload octets
    input  wire logic [4:0] n_tag,      // tag octets after the body
    output octet_s          res_in,     // result octets
    output logic            busy        // results still pending
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] q[$];
    int         idx;

    // body first, then the tag: the c data layout of the engine
    function automatic logic [7:0] res_of(input int i);
        if (i < n_body) return q[i] ^ 8'h5A;
        return 8'hC0 + 8'(i);
    endfunction

    // an octet is held until taken; idle data is the inverted last value
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            res_in <= '0;
            busy <= 1'b0;
            idx <= 0;
            q.delete();
        end else begin
            if (eng_m.valid) q.push_back(eng_m.data);
            if (go) begin
                busy <= 1'b1;
                idx <= 0;
            end else if (busy && (!res_in.valid || res_ready)) begin
                if (idx == int'(n_body) + int'(n_tag) ||
                    (res_in.valid && slow)) begin
                    res_in <= '{1'b0, ~res_in.data};
                    if (!(res_in.valid && slow)) busy <= 1'b0;
                    if (!(res_in.valid && slow)) q.delete();
                end else begin
                    res_in <= '{1'b1, res_of(idx)};
                    idx <= idx + 1;
                end
            end
        end
    end
endmodule

// [bench/tb_top.sv]
// bench top: random frames at every level, both directions, registers
// assumes the formatter package and the engine stand-in beside it
module tb_top
    import ccm_fmt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic             clock;
    logic             rstn;
    logic [3:0]       reg_addr;
    logic [31:0]      reg_wdata;
    logic             reg_wr;
    logic             reg_rd;
    logic [31:0]      reg_rdata;
    frame_octet_s     frm_in;
    octet_s           res_in;
    logic             res_ready;
    octet_s           eng_a;
    octet_s           eng_m;
    octet_s           frm_out;
    logic             frm_end;
    eng_cfg_s         eng_cfg;
    logic [12:0][7:0] nonce;
    logic             go;
    logic             slow;
    logic [4:0]       n_body;
    logic [4:0]       n_tag;
    logic             busy;
    logic [31:0]      seed;
    logic [2:0]       lvl;
    logic             act;
    logic             enc;
    logic             inv;
    logic [7:0]       xa[$], xm[$], xo[$], ga[$], gm[$], gq[$];
    int               err_total, checks, cyc, ends;

    ccm_frame_security_formatter u_dut (.clock(clock), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frm_in(frm_in),
        .res_in(res_in), .res_ready(res_ready), .eng_a(eng_a),
        .eng_m(eng_m), .frm_out(frm_out), .frm_end(frm_end),
        .eng_cfg(eng_cfg), .nonce(nonce));
    ccm_engine_model u_eng (.clock(clock), .rstn(rstn), .eng_m(eng_m),
        .res_ready(res_ready), .go(go), .slow(slow), .n_body(n_body),
        .n_tag(n_tag), .res_in(res_in), .busy(busy));

    // clock, and a cycle ceiling so a hang still reaches the verdict
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    // collect what the formatter emits, sampled before this edge's updates
    always @(posedge clock) begin
        if (eng_a.valid) ga.push_back(eng_a.data);
        if (eng_m.valid) gm.push_back(eng_m.data);
        if (frm_out.valid) gq.push_back(frm_out.data);
        if (frm_end) ends++;
    end

    function automatic logic [31:0] rnd();
        for (int i = 0; i < 32; i++)
            seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic cmpq(input string n, input logic [7:0] g[$],
                        input logic [7:0] x[$]);
        chk({n, " count"}, g.size(), x.size());
        for (int i = 0; i < x.size() && i < g.size(); i++) chk(n, g[i], x[i]);
    endtask
    // one-cycle strobes; read data is taken in the cycle after the strobe
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // drive one frame octet and note where the routing should send it
    task automatic put(input sect_e s, input logic [7:0] d, input logic l);
        @(posedge clock);
        frm_in <= '{1'b1, d, s, l};
        if (s < SECT_PAYLOAD) begin
            xo.push_back(d);
            if (act && (inv || lvl != LEVEL_ENC_ONLY)) xa.push_back(d);
        end else if (s == SECT_PAYLOAD) begin
            if (act && !enc) xa.push_back(d);
            if (act && enc) xm.push_back(d);
            else xo.push_back(d);
        end else begin
            if (act && inv) xm.push_back(d);
            if (!act) xo.push_back(d);
        end
    endtask
    // one secured frame at level l, inverse when v, then the engine results
    task automatic run(input logic [2:0] l, input logic v);
        logic [31:0]      cnt, hi, lo, r;
        logic [1:0]       k;
        logic [7:0]       pl[4];
        logic [12:0][7:0] xn;
        int               np, nt, nk;
        lo = rnd();
        hi = rnd();
        cnt = rnd();
        r = rnd();
        k = r[1:0];
        np = 1 + r[3:2];
        nk = (k == 0) ? 0 : 4 * k - 3;
        nt = (l[1:0] == 0) ? 0 : 2 << l[1:0];
        lvl = l;
        inv = v;
        act = (l != 0);
        enc = l[2];
        xn = {5'h00, l, cnt, hi, lo};
        wr(REG_ADDR_LO, lo);
        wr(REG_ADDR_HI, hi);
        wr(REG_CTRL, {27'h0, 1'b1, v, l});
        xa = {};
        xm = {};
        xo = {};
        ga = {};
        gm = {};
        gq = {};
        ends = 0;
        put(SECT_HDR, r[15:8], 1'b0);
        put(SECT_HDR, r[23:16], 1'b0);
        put(SECT_AUX, {3'h0, k, l}, 1'b0);
        for (int i = 0; i < 4; i++) put(SECT_AUX, cnt[8*i +: 8], 1'b0);
        for (int i = 0; i < nk; i++) put(SECT_AUX, 8'(rnd()), 1'b0);
        put(SECT_NONPAY, r[31:24], 1'b0);
        for (int i = 0; i < np; i++) begin
            pl[i] = 8'(rnd());
            put(SECT_PAYLOAD, pl[i], i == np - 1 && (!v || nt == 0));
        end
        for (int i = 0; i < nt && v; i++)
            put(SECT_TAG, 8'(rnd()), i == nt - 1);
        @(posedge clock);
        frm_in <= '0;
        repeat (3) @(posedge clock);
        cmpq("a data", ga, xa);
        cmpq("m data", gm, xm);
        cmpq("frame out", gq, xo);
        chk("frame end", ends, 1);
        chk("cfg", 32'(eng_cfg),
            {act, v, enc, 5'(nt), 2'h2, 1'b1});
        for (int i = 0; i < 13; i++) chk("nonce", nonce[i], xn[i]);
        rd(REG_STATUS, r);
        chk("status", r[7:0] & 8'hDF, {3'h0, k, l});
        rd(REG_COUNTER, r);
        chk("counter", r, cnt);
        gq = {};
        xo = {};
        for (int i = 0; i < np && enc; i++) xo.push_back(pl[i] ^ 8'h5A);
        for (int i = 0; i < nt && !v; i++)
            xo.push_back(8'hC0 + 8'(xo.size()));
        @(posedge clock);
        n_body <= enc ? 5'(np) : 5'h00;
        n_tag <= v ? 5'h00 : 5'(nt);
        slow <= l[0];
        // nonce is settled before the engine is started
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        for (int i = 0; i < 200 && (i < 2 || busy); i++) @(posedge clock);
        repeat (2) @(posedge clock);
        cmpq("result out", gq, xo);
    endtask

    // reset, registers, every level both ways, then two layout faults
    initial begin
        logic [31:0] r;
        {frm_in, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {go, slow, n_body, n_tag, lvl, act, enc, inv} = '0;
        {err_total, checks, cyc, ends} = '0;
        seed = 32'hDE61A79C;
        rstn = 1'b0;
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        #1 chk("reset cfg", 32'(eng_cfg), {8'h00, 2'h2, 1'b1});
        chk("reset nonce", 32'(nonce), 32'h0);
        rd(REG_CTRL, r);
        chk("ctrl reset", r, 32'(CTRL_RESET));
        wr(REG_ADDR_HI, 32'h89ABCDEF);
        wr(4'hF, 32'hFFFFFFFF);
        rd(REG_ADDR_HI, r);
        chk("addr hi", r, 32'h89ABCDEF);
        rd(4'hF, r);
        chk("unmapped", r, 32'h0);
        wr(REG_CTRL, 32'h3D);
        rd(REG_CTRL, r);
        chk("ctrl", r, 32'h1D);
        for (int l = 0; l < 8; l++)
            for (int v = 0; v < 2; v++) run(3'(l), 1'(v));
        act = 1'b0;
        wr(REG_CTRL, 32'h0);
        put(SECT_HDR, 8'h41, 1'b0);
        put(SECT_AUX, 8'h05, 1'b0);
        put(SECT_PAYLOAD, 8'h11, 1'b1);
        @(posedge clock);
        frm_in <= '0;
        rd(REG_STATUS, r);
        chk("layout err", r[6], 1);
        chk("level mismatch", r[7], 1);
        wr(REG_CTRL, 32'h20);
        rd(REG_STATUS, r);
        chk("err clear", r[7:6], 0);
        // body octet before any aux header while security is on
        wr(REG_CTRL, 32'h11);
        put(SECT_HDR, 8'h42, 1'b0);
        put(SECT_PAYLOAD, 8'h12, 1'b1);
        @(posedge clock);
        frm_in <= '0;
        rd(REG_STATUS, r);
        chk("early body", r[6], 1);
        print_verdict();
    end
endmodule
